// file: logic/nax_exec.sv
// Arithmetic execution datapath: accumulator, carry, index pointer and RAM sequencing.
// Assumes a data RAM with registered read (one cycle latency) on the same clock.
//
// Summary of operation
// RULE_01 - Direct increment: memory nibble plus one to memory and accumulator.
// RULE_02 - Indirect increment: pointed nibble plus one to memory and accumulator.
// RULE_03 - Direct decrement: memory nibble minus one to memory and accumulator.
// RULE_04 - Indirect decrement: pointed nibble minus one to memory and accumulator.
// RULE_05 - Increment, decrement, add, add-carry, subtract, subtract-borrow update carry.
// RULE_06 - Post-increment variants advance the pointer after using its old value.
// RULE_07 - Direct add-carry: memory plus accumulator plus carry into accumulator.
// RULE_08 - Indirect add-carry: pointed nibble plus accumulator plus carry.
// RULE_09 - Direct subtract-borrow: memory plus inverted accumulator plus carry.
// RULE_10 - Indirect subtract-borrow: pointed nibble plus inverted accumulator plus carry.
// RULE_11 - Direct subtract: memory plus inverted accumulator plus one.
// RULE_12 - Indirect subtract: pointed nibble plus inverted accumulator plus one.
// RULE_13 - Indirect add: pointed nibble plus accumulator, carry updated.
// RULE_14 - Carryless add: sum into accumulator, carry unchanged.
// RULE_15 - Store-back variants write result to memory and accumulator.
// RULE_16 - Variants without store-back leave memory untouched.
// RULE_17 - Indirect forms address memory through the index pointer.
// RULE_18 - Flag transfer: carry in bit 3, accumulator-zero in bit 2.
// RULE_19 - Four-bit modulo arithmetic; carry is carry-out or no-borrow.
// RULE_20 - Pointer wraps within RAM range; write uses the pre-increment address.
`timescale 1ns/1ps
`include "nax_consts.svh"

module nax_exec #(
   parameter int ADDR_W = `NAX_ADDR_W
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic op_valid,
   input wire nax_pkg::nax_cmd_s op_cmd,
   input wire logic [ADDR_W-1:0] op_addr,
   output logic op_ready,
   output logic op_done,
   input wire logic ptr_load,
   input wire logic [ADDR_W-1:0] ptr_load_value,
   output logic [ADDR_W-1:0] index_pointer,
   output logic [`NAX_DATA_W-1:0] accumulator_nibble,
   output logic carry_bit,
   output logic [ADDR_W-1:0] ram_addr,
   output logic ram_rd_en,
   output logic ram_wr_en,
   output logic [`NAX_DATA_W-1:0] ram_wdata,
   input wire logic [`NAX_DATA_W-1:0] ram_rdata
);

   // Increment, decrement and flag transfer always write memory
   function automatic logic needs_store(input nax_pkg::nax_cmd_s cmd);
      needs_store = cmd.store_back
         || (cmd.op == nax_pkg::NAX_OP_INC)
         || (cmd.op == nax_pkg::NAX_OP_DEC)
         || (cmd.op == nax_pkg::NAX_OP_FLG);
   endfunction

   // Pointer advance only applies to indirect forms
   function automatic logic needs_advance(input nax_pkg::nax_cmd_s cmd);
      needs_advance = cmd.indirect && cmd.post_inc;
   endfunction

   nax_pkg::nax_state_e state;
   nax_pkg::nax_state_e next_state;
   nax_pkg::nax_cmd_s cur_cmd;
   logic accept;
   logic [`NAX_DATA_W-1:0] alu_result;
   logic alu_carry;
   logic alu_carry_we;

   assign accept = op_valid && op_ready;

   nax_alu u_alu (
      .op(cur_cmd.op),
      .mem_val(ram_rdata),
      .acc_val(accumulator_nibble),
      .carry_in(carry_bit),
      .result(alu_result),
      .carry_out(alu_carry),
      .carry_we(alu_carry_we)
   );

   // Sequencer
   always_comb begin
      next_state = state;
      case (state)
         nax_pkg::NAX_ST_IDLE: begin
            if (accept) begin
               next_state = nax_pkg::NAX_ST_READ;
            end
         end
         nax_pkg::NAX_ST_READ: next_state = nax_pkg::NAX_ST_EXEC;
         nax_pkg::NAX_ST_EXEC: next_state = nax_pkg::NAX_ST_WRITE;
         nax_pkg::NAX_ST_WRITE: next_state = nax_pkg::NAX_ST_IDLE;
         default: next_state = nax_pkg::NAX_ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state <= nax_pkg::NAX_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Command capture
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         cur_cmd <= '0;
      end else if (accept) begin
         cur_cmd <= op_cmd;
      end
   end

   // Handshake outputs
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         op_ready <= 1'b0;
         op_done <= 1'b0;
      end else begin
         op_ready <= (next_state == nax_pkg::NAX_ST_IDLE);
         op_done <= (state == nax_pkg::NAX_ST_EXEC);
      end
   end

   // Operand address is held from the read to the write-back
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         ram_addr <= '0;
         ram_rd_en <= 1'b0;
      end else begin
         ram_rd_en <= accept;
         if (accept) begin
            ram_addr <= op_cmd.indirect ? index_pointer : op_addr; // [RULE_17] [RULE_20]
         end
      end
   end

   // Result write-back to memory
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         ram_wr_en <= 1'b0;
         ram_wdata <= '0;
      end else begin
         ram_wr_en <= (state == nax_pkg::NAX_ST_EXEC) && needs_store(cur_cmd); // [RULE_15] [RULE_16]
         if (state == nax_pkg::NAX_ST_EXEC) begin
            ram_wdata <= alu_result; // [RULE_01] [RULE_02] [RULE_03] [RULE_04] [RULE_15]
         end
      end
   end

   // Accumulator
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         accumulator_nibble <= `NAX_ACC_RST;
      end else if (state == nax_pkg::NAX_ST_EXEC) begin
         accumulator_nibble <= alu_result; // [RULE_07] [RULE_08] [RULE_09] [RULE_10] [RULE_18]
      end
   end

   // Carry flag
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         carry_bit <= `NAX_CARRY_RST;
      end else if ((state == nax_pkg::NAX_ST_EXEC) && alu_carry_we) begin
         carry_bit <= alu_carry; // [RULE_05] [RULE_13] [RULE_14] [RULE_19]
      end
   end

   // Index pointer: load while idle, advance after the operation
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         index_pointer <= `NAX_PTR_RST;
      end else if ((state == nax_pkg::NAX_ST_EXEC) && needs_advance(cur_cmd)) begin
         index_pointer <= index_pointer + ADDR_W'(1); // [RULE_06] [RULE_20]
      end else if ((state == nax_pkg::NAX_ST_IDLE) && ptr_load && !op_valid) begin
         index_pointer <= ptr_load_value;
      end
   end

   // Checks
   logic [ADDR_W-1:0] chk_old_ptr;
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         chk_old_ptr <= '0;
      end else if (accept) begin
         chk_old_ptr <= index_pointer;
      end
   end

   chk_operand_addr: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_17]
      accept |=> ram_rd_en
         && (ram_addr == ($past(op_cmd.indirect) ? $past(index_pointer) : $past(op_addr))))
      else $error("operand address does not match addressing mode");

   chk_write_addr: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_20]
      $rose(ram_rd_en) |-> ##2 (ram_addr == $past(ram_addr, 2)))
      else $error("write-back address moved after the read");

   chk_no_store: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_16]
      (accept && !needs_store(op_cmd)) |-> ##3 !ram_wr_en)
      else $error("memory written by a variant without store-back");

   chk_store_data: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_15]
      (accept && needs_store(op_cmd)) |-> ##3 (ram_wr_en && op_done
         && (ram_wdata == accumulator_nibble)))
      else $error("store-back missing or differs from accumulator");

   chk_inc_value: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_01] [RULE_02]
      ((state == nax_pkg::NAX_ST_EXEC) && (cur_cmd.op == nax_pkg::NAX_OP_INC))
      |=> (accumulator_nibble == 4'($past(ram_rdata) + 4'h1))
         && (carry_bit == ($past(ram_rdata) == 4'hF)))
      else $error("increment result or carry wrong");

   chk_dec_value: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_03] [RULE_04]
      ((state == nax_pkg::NAX_ST_EXEC) && (cur_cmd.op == nax_pkg::NAX_OP_DEC))
      |=> (accumulator_nibble == 4'($past(ram_rdata) - 4'h1))
         && (carry_bit == ($past(ram_rdata) != 4'h0)))
      else $error("decrement result or carry wrong");

   chk_sub_value: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_11] [RULE_12]
      ((state == nax_pkg::NAX_ST_EXEC) && (cur_cmd.op == nax_pkg::NAX_OP_SUB))
      |=> (accumulator_nibble == 4'($past(ram_rdata) - $past(accumulator_nibble)))
         && (carry_bit == ($past(ram_rdata) >= $past(accumulator_nibble))))
      else $error("subtract result or no-borrow carry wrong");

   chk_adc_value: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_07] [RULE_08]
      ((state == nax_pkg::NAX_ST_EXEC) && (cur_cmd.op == nax_pkg::NAX_OP_ADC))
      |=> ({carry_bit, accumulator_nibble} == 5'({1'b0, $past(ram_rdata)}
         + {1'b0, $past(accumulator_nibble)} + {4'h0, $past(carry_bit)})))
      else $error("add-with-carry result wrong");

   chk_adn_carry: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_14]
      ((state == nax_pkg::NAX_ST_EXEC) && (cur_cmd.op == nax_pkg::NAX_OP_ADN))
      |=> $stable(carry_bit))
      else $error("carryless add changed the carry");

   chk_flag_bits: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_18]
      ((state == nax_pkg::NAX_ST_EXEC) && (cur_cmd.op == nax_pkg::NAX_OP_FLG))
      |=> (accumulator_nibble == {$past(carry_bit), ($past(accumulator_nibble) == 4'h0), 2'b00}))
      else $error("flag transfer bits wrong");

   chk_ptr_advance: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_06]
      (accept && needs_advance(op_cmd)) |-> ##3
         (index_pointer == chk_old_ptr + ADDR_W'(1)) && (ram_addr == chk_old_ptr))
      else $error("pointer not advanced after using the old value");

   chk_sbc_value: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_09] [RULE_10]
      ((state == nax_pkg::NAX_ST_EXEC) && (cur_cmd.op == nax_pkg::NAX_OP_SBC))
      |=> ({carry_bit, accumulator_nibble} == 5'({1'b0, $past(ram_rdata)}
         + {1'b0, ~$past(accumulator_nibble)} + {4'h0, $past(carry_bit)})))
      else $error("subtract-with-borrow result wrong");

   chk_add_value: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_13]
      ((state == nax_pkg::NAX_ST_EXEC) && (cur_cmd.op == nax_pkg::NAX_OP_ADD))
      |=> ({carry_bit, accumulator_nibble} == 5'({1'b0, $past(ram_rdata)}
         + {1'b0, $past(accumulator_nibble)})))
      else $error("add result or carry wrong");

   chk_adn_value: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_14]
      ((state == nax_pkg::NAX_ST_EXEC) && (cur_cmd.op == nax_pkg::NAX_OP_ADN))
      |=> (accumulator_nibble == 4'($past(ram_rdata) + $past(accumulator_nibble))))
      else $error("carryless add result wrong");

   chk_flag_carry: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_05]
      ((state == nax_pkg::NAX_ST_EXEC) && (cur_cmd.op == nax_pkg::NAX_OP_FLG))
      |=> $stable(carry_bit))
      else $error("flag transfer changed the carry");

   chk_carry_steady: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_05]
      (state != nax_pkg::NAX_ST_EXEC) |=> $stable(carry_bit))
      else $error("carry changed outside execution");

   chk_acc_steady: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_16]
      (state != nax_pkg::NAX_ST_EXEC) |=> $stable(accumulator_nibble))
      else $error("accumulator changed outside execution");

   chk_wr_window: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_16]
      ram_wr_en |-> (state == nax_pkg::NAX_ST_WRITE))
      else $error("memory write outside the write-back cycle");

   chk_rd_pulse: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_17]
      ram_rd_en |=> !ram_rd_en)
      else $error("read strobe longer than one cycle");

   chk_wr_pulse: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_15]
      ram_wr_en |=> !ram_wr_en)
      else $error("write strobe longer than one cycle");

   chk_done_pulse: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_15]
      op_done |=> !op_done && op_ready)
      else $error("done not a single pulse followed by ready");

   chk_ready_gap: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_06]
      accept |=> !op_ready ##1 !op_ready ##1 !op_ready ##1 op_ready)
      else $error("ready not low for exactly three cycles");

   chk_done_delay: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_06]
      accept |-> ##3 op_done)
      else $error("done not three cycles after the command");

   chk_ptr_steady: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_06]
      ((state != nax_pkg::NAX_ST_IDLE)
         && !((state == nax_pkg::NAX_ST_EXEC) && needs_advance(cur_cmd)))
      |=> $stable(index_pointer))
      else $error("pointer moved without a post-increment");

   chk_ptr_load: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_17]
      ((state == nax_pkg::NAX_ST_IDLE) && ptr_load && !op_valid)
      |=> (index_pointer == $past(ptr_load_value)))
      else $error("pointer load not taken while idle");

   chk_ptr_refuse: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_17]
      ((state == nax_pkg::NAX_ST_IDLE) && ptr_load && op_valid)
      |=> $stable(index_pointer))
      else $error("pointer load taken together with a command");

   chk_ptr_wrap: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_20]
      ((state == nax_pkg::NAX_ST_EXEC) && needs_advance(cur_cmd) && (&index_pointer))
      |=> (index_pointer == '0))
      else $error("pointer did not wrap to zero");

   chk_addr_steady: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_20]
      (state != nax_pkg::NAX_ST_IDLE) |=> $stable(ram_addr))
      else $error("operand address moved during an operation");

   chk_cmd_steady: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_17]
      (state != nax_pkg::NAX_ST_IDLE) |=> $stable(cur_cmd))
      else $error("command changed during an operation");

   chk_pre_inc_write: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_20]
      (ram_wr_en && needs_advance(cur_cmd)) |-> (ram_addr == chk_old_ptr))
      else $error("write-back not at the pre-increment address");

   chk_flag_store: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_18]
      ((state == nax_pkg::NAX_ST_EXEC) && (cur_cmd.op == nax_pkg::NAX_OP_FLG))
      |=> ram_wr_en)
      else $error("flag transfer not written to memory");

   chk_step_store: assert property (@(posedge core_clk) disable iff (!rstn) // [RULE_01] [RULE_03]
      ((state == nax_pkg::NAX_ST_EXEC) && ((cur_cmd.op == nax_pkg::NAX_OP_INC)
         || (cur_cmd.op == nax_pkg::NAX_OP_DEC)))
      |=> ram_wr_en)
      else $error("increment or decrement not written to memory");

endmodule

// file: logic/nax_consts.svh
// Constants of the nibble arithmetic execution datapath.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef NAX_CONSTS_SVH
`define NAX_CONSTS_SVH

// Datapath and data-memory address widths
`define NAX_DATA_W 4
`define NAX_ADDR_W 9

// Reset values
`define NAX_ACC_RST 4'h0
`define NAX_CARRY_RST 1'b0
`define NAX_PTR_RST 9'h000

// Flag transfer bit positions
`define NAX_FLAG_CARRY_POS 3
`define NAX_FLAG_ZERO_POS 2

// Operand constants
`define NAX_ONE 4'h1
`define NAX_MINUS_ONE 4'hF

`endif

// file: logic/nax_pkg.sv
// Types shared by the nibble arithmetic execution datapath.
// Assumes the decoder presents one command at a time with a valid strobe.
package nax_pkg;

   typedef enum logic [2:0] {
      NAX_OP_INC = 3'b000,
      NAX_OP_DEC = 3'b001,
      NAX_OP_ADD = 3'b010,
      NAX_OP_ADC = 3'b011,
      NAX_OP_SUB = 3'b100,
      NAX_OP_SBC = 3'b101,
      NAX_OP_ADN = 3'b110,
      NAX_OP_FLG = 3'b111
   } nax_op_e;

   typedef enum logic [1:0] {
      NAX_ST_IDLE = 2'b00,
      NAX_ST_READ = 2'b01,
      NAX_ST_EXEC = 2'b10,
      NAX_ST_WRITE = 2'b11
   } nax_state_e;

   typedef struct packed {
      nax_op_e op;
      logic indirect;
      logic store_back;
      logic post_inc;
   } nax_cmd_s;

endpackage

// file: logic/nax_alu.sv
// Combinational nibble adder for all arithmetic variants.
// Assumes operands are stable while the caller samples the result.
`timescale 1ns/1ps
`include "nax_consts.svh"

module nax_alu (
   input wire nax_pkg::nax_op_e op,
   input wire logic [`NAX_DATA_W-1:0] mem_val,
   input wire logic [`NAX_DATA_W-1:0] acc_val,
   input wire logic carry_in,
   output logic [`NAX_DATA_W-1:0] result,
   output logic carry_out,
   output logic carry_we
);

   logic [`NAX_DATA_W:0] sum;

   always_comb begin
      sum = '0;
      carry_we = 1'b1;
      case (op)
         nax_pkg::NAX_OP_INC: sum = {1'b0, mem_val} + {1'b0, `NAX_ONE};
         nax_pkg::NAX_OP_DEC: sum = {1'b0, mem_val} + {1'b0, `NAX_MINUS_ONE};
         nax_pkg::NAX_OP_ADD: sum = {1'b0, mem_val} + {1'b0, acc_val}; // [RULE_13]
         nax_pkg::NAX_OP_ADC: sum = {1'b0, mem_val} + {1'b0, acc_val} + {4'h0, carry_in};
         nax_pkg::NAX_OP_SUB: sum = {1'b0, mem_val} + {1'b0, ~acc_val} + 5'h01;
         nax_pkg::NAX_OP_SBC: sum = {1'b0, mem_val} + {1'b0, ~acc_val} + {4'h0, carry_in};
         nax_pkg::NAX_OP_ADN: begin
            sum = {1'b0, mem_val} + {1'b0, acc_val};
            carry_we = 1'b0; // [RULE_14]
         end
         nax_pkg::NAX_OP_FLG: begin
            sum = '0;
            sum[`NAX_FLAG_CARRY_POS] = carry_in;
            sum[`NAX_FLAG_ZERO_POS] = (acc_val == 4'h0);
            carry_we = 1'b0;
         end
         default: sum = '0;
      endcase
      result = sum[`NAX_DATA_W-1:0]; // [RULE_11] [RULE_12]
      carry_out = sum[`NAX_DATA_W]; // [RULE_19]
   end

endmodule

// file: dv/test_nax_exec.sv
// Self-checking bench for the nibble arithmetic execution datapath.
// Assumes nax_exec with default widths; the bench itself plays the registered data RAM.
`timescale 1ns/1ps
`include "nax_consts.svh"

module test_nax_exec;
   logic core_clk, rstn, op_valid, ptr_load;
   nax_pkg::nax_cmd_s op_cmd;
   logic [8:0] op_addr, ptr_load_value, index_pointer, ram_addr, exp_ptr;
   logic op_ready, op_done, carry_bit, ram_rd_en, ram_wr_en, exp_cy;
   logic [3:0] accumulator_nibble, ram_wdata, ram_rdata, exp_acc;
   logic [3:0] mem [512];
   int miscompares = 0;
   int samples_checked = 0;

   nax_exec i_nax_exec (.core_clk(core_clk), .rstn(rstn), .op_valid(op_valid),
      .op_cmd(op_cmd), .op_addr(op_addr), .op_ready(op_ready), .op_done(op_done),
      .ptr_load(ptr_load), .ptr_load_value(ptr_load_value), .index_pointer(index_pointer),
      .accumulator_nibble(accumulator_nibble), .carry_bit(carry_bit), .ram_addr(ram_addr),
      .ram_rd_en(ram_rd_en), .ram_wr_en(ram_wr_en), .ram_wdata(ram_wdata),
      .ram_rdata(ram_rdata));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Registered RAM; read data scrambles when no read is pending
   always @(posedge core_clk) begin
      if (ram_wr_en === 1'b1) mem[ram_addr] <= ram_wdata;
      if (ram_rd_en === 1'b1) ram_rdata <= mem[ram_addr];
      else ram_rdata <= ~ram_rdata;
   end

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Reference: {carry updated, carry, result}
   function automatic logic [5:0] ref_calc(input logic [2:0] op, input logic [3:0] m,
         input logic [3:0] a, input logic c);
      logic [4:0] s;
      case (op)
         3'h0: s = {1'b0, m} + 5'h01;
         3'h1: s = {1'b0, m} + 5'h0F;
         3'h2: s = {1'b0, m} + {1'b0, a};
         3'h3: s = {1'b0, m} + {1'b0, a} + {4'h0, c};
         3'h4: s = {1'b0, m} + {1'b0, ~a} + 5'h01;
         3'h5: s = {1'b0, m} + {1'b0, ~a} + {4'h0, c};
         3'h6: s = {c, m + a};
         default: s = {c, c, (a == 4'h0), 2'b00};
      endcase
      return {(op < 3'h6), s};
   endfunction

   task automatic do_op(input logic [2:0] op, input logic ind, st, pi, pl,
         input logic [8:0] adr);
      logic [8:0] a;
      logic [5:0] r;
      logic [3:0] old;
      logic wr;
      int n;
      a = ind ? exp_ptr : adr;
      old = mem[a];
      r = ref_calc(op, old, exp_acc, exp_cy);
      wr = (op == 3'h0 || op == 3'h1 || op == 3'h7) ? 1'b1 : st;
      @(negedge core_clk);
      op_cmd = nax_pkg::nax_cmd_s'({op, ind, st, pi});
      op_addr = adr;
      op_valid = 1'b1;
      ptr_load = pl;
      ptr_load_value = 9'h0AA;
      n = 0;
      while (op_ready !== 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      @(negedge core_clk);
      op_valid = 1'b0;
      ptr_load = 1'b0;
      chk("ram_rd_en", ram_rd_en, 1);
      chk("ram_addr", ram_addr, a);
      repeat (2) @(negedge core_clk);
      exp_acc = r[3:0];
      if (r[5]) exp_cy = r[4];
      if (ind && pi) exp_ptr = exp_ptr + 9'h001;
      chk("op_done", op_done, 1);
      chk("acc", accumulator_nibble, exp_acc);
      chk("carry", carry_bit, exp_cy);
      chk("pointer", index_pointer, exp_ptr);
      chk("ram_wr_en", ram_wr_en, wr);
      if (wr) chk("ram_wdata", ram_wdata, r[3:0]);
      if (wr) chk("wr_addr", ram_addr, a);
      @(negedge core_clk);
      chk("mem", mem[a], wr ? r[3:0] : old);
      chk("op_done_low", op_done, 0);
      chk("op_ready", op_ready, 1);
   endtask

   task automatic load_ptr(input logic [8:0] v);
      @(negedge core_clk);
      ptr_load = 1'b1;
      ptr_load_value = v;
      @(negedge core_clk);
      ptr_load = 1'b0;
      exp_ptr = v;
      chk("ptr_load", index_pointer, v);
   endtask

   task automatic t_incdec();
      mem[9'h010] = 4'hF;
      do_op(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 9'h010);
      do_op(3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 9'h010);
      load_ptr(9'h123);
      mem[9'h123] = 4'h7;
      do_op(3'h0, 1'b1, 1'b0, 1'b0, 1'b0, 9'h010);
      do_op(3'h1, 1'b1, 1'b0, 1'b0, 1'b0, 9'h010);
      mem[9'h123] = 4'h0;
      do_op(3'h1, 1'b1, 1'b0, 1'b0, 1'b0, 9'h010);
   endtask

   task automatic t_arith();
      for (int k = 0; k < 32; k++) begin
         mem[9'h040 + k] = 4'(k * 5 + 3);
         mem[exp_ptr] = 4'(k * 3 + 9);
         // Ops 2..5 by k, direct or pointer, with and without store-back
         do_op(3'(2 + k % 4), k[2], k[3], 1'b0, 1'b0, 9'h040 + 9'(k));
      end
   endtask

   task automatic t_carryless();
      mem[9'h050] = 4'hC;
      do_op(3'h2, 1'b0, 1'b0, 1'b0, 1'b0, 9'h050);
      do_op(3'h6, 1'b0, 1'b1, 1'b0, 1'b0, 9'h050);
      do_op(3'h6, 1'b1, 1'b0, 1'b1, 1'b0, 9'h050);
   endtask

   task automatic t_postinc();
      load_ptr(9'h1FE);
      for (int k = 0; k < 6; k++) begin
         mem[exp_ptr] = 4'(k + 10);
         do_op(3'(k), 1'b1, 1'b1, 1'b1, 1'b0, 9'h000);
      end
      do_op(3'h4, 1'b0, 1'b1, 1'b1, 1'b0, 9'h033);
   endtask

   task automatic t_flag();
      mem[9'h060] = 4'hF;
      do_op(3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 9'h060);
      do_op(3'h7, 1'b0, 1'b0, 1'b0, 1'b0, 9'h061);
      do_op(3'h7, 1'b0, 1'b0, 1'b0, 1'b0, 9'h062);
   endtask

   task automatic t_refuse();
      do_op(3'h3, 1'b1, 1'b0, 1'b0, 1'b1, 9'h070);
   endtask

   task automatic end_of_test();
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   initial begin
      #200000;
      miscompares++;
      end_of_test();
   end

   initial begin
      rstn = 1'b0;
      op_valid = 1'b0;
      op_cmd = '0;
      op_addr = '0;
      ptr_load = 1'b0;
      ptr_load_value = '0;
      exp_acc = `NAX_ACC_RST;
      exp_cy = `NAX_CARRY_RST;
      exp_ptr = `NAX_PTR_RST;
      for (int i = 0; i < 512; i++) mem[i] = 4'(i);
      repeat (5) @(negedge core_clk);
      chk("rst_ready", op_ready, 0);
      chk("rst_acc", accumulator_nibble, 0);
      rstn = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("rst_carry", carry_bit, 0);
      chk("rst_ptr", index_pointer, 0);
      t_incdec();
      t_arith();
      t_carryless();
      t_postinc();
      t_flag();
      t_refuse();
      end_of_test();
   end
endmodule
